/* File: bench/pcc_chk.sv */
// port checker for the pll clock output control
`default_nettype none
module pcc_chk (
  // clock and reset
  input wire logic core_clk_in, nrst_in,
  // bus handshakes
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pll and trim state
  input wire logic pll_div_reserved_out,
  input wire logic [7:0] slow_osc_trim_value_out,
  input wire logic [15:0] pll_out_khz_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_wr_answer: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_trim_write: assert property ($changed(slow_osc_trim_value_out) |-> $rose(s_axi_bvalid))
    else $error("trim changed without write");
  a_div_stop: assert property (pll_div_reserved_out |-> pll_out_khz_out == 16'h0)
    else $error("pll runs with reserved divider");
  a_out_write: assert property ($changed(pll_out_khz_out) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(!nrst_in))
    else $error("pll output changed without write");
endmodule
bind pcc_top pcc_chk u_chk (.*);
`default_nettype wire

/* File: bench/pcc_pin_model.sv */
// clock pin load: resolves the line and counts its rising edges
`default_nettype none
module pcc_pin_model (
  input wire logic core_clk_in,
  input wire logic pin_in,
  input wire logic oe_in,
  output logic line_out,
  output int rises_out
);
  logic prev_ff = 1'b1;
  initial rises_out = 0;
  // pull-up holds the line when undriven
  assign line_out = oe_in ? pin_in : 1'b1;
  always @(posedge core_clk_in) begin
    prev_ff <= line_out;
    if (line_out && !prev_ff) rises_out <= rises_out + 1;
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// testbench for the pll clock output control
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, nrst_in = 0, ce_in = 1, xtal_clk_in = 0;
  logic gpio_out_in = 0, gpio_oe_in = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf, timer_overflow_in = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic clock_output_pin_in, clock_output_pin_out, clock_output_pin_oe_out;
  wire logic pll_clk_out, pll_div_reserved_out;
  wire logic [7:0] slow_osc_trim_value_out;
  wire logic [15:0] pll_vco_khz_out, pll_out_khz_out;
  int rises, num_errors = 0, samples_checked = 0;
  int fbf[4] = '{23, 27, 28, 23};
  pcc_top dut_u (.*);
  pcc_pin_model pin_u (.core_clk_in(core_clk_in), .pin_in(clock_output_pin_out),
    .oe_in(clock_output_pin_oe_out), .line_out(clock_output_pin_in), .rises_out(rises));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, tr, fin;
    int n;
    fin = 0;
    @(posedge core_clk_in);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    for (n = 0; n < 40 && !fin; n++) begin
      @(negedge core_clk_in);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      fin = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge core_clk_in);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
    end
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    chk("answer", fin, 1);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    bus(1, a, d, q, r);
    chk("bresp", r, er);
    repeat (4) @(negedge core_clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    bus(0, a, 0, q, r);
    chk("rresp", r, er);
    if (er == 0) chk("rdata", q, e);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(12'h0f0, 32'h80, 0);
    rd(12'h0f4, 32'h00, 0);
    rd(12'h0f8, 32'h08, 0);
    wr(12'h0f0, 32'hffff_ff3c, 0);
    rd(12'h0f0, 32'h3c, 0);
    chk("trim", slow_osc_trim_value_out, 8'h3c);
    rd(12'h200, 0, 2);
    wr(12'h204, 5, 2);
  endtask
  task automatic t_pll;
    int f, d;
    for (f = 0; f < 4; f++) begin
      for (d = 8; d <= 10; d += 2) begin
        wr(12'h0f8, d, 0);
        wr(12'h0f4, f, 0);
        chk("pll_out", pll_out_khz_out, 13560 * fbf[f] / d);
      end
    end
    wr(12'h0f4, 32'h04, 0);
    chk("pd_vco", pll_vco_khz_out, 0);
    chk("pd_out", pll_out_khz_out, 0);
    wr(12'h0f4, 32'h00, 0);
    wr(12'h0f8, 32'h07, 0);
    chk("div_rsv", pll_div_reserved_out, 1);
    chk("rsv_out", pll_out_khz_out, 0);
    wr(12'h0f8, 32'h08, 0);
  endtask
  task automatic t_pll_pin;
    int e0;
    wr(12'h0f4, 32'h1a, 0);
    chk("vco", pll_vco_khz_out, 13560 * 28 / 16);
    @(posedge core_clk_in) e0 = rises;
    repeat (256) @(posedge core_clk_in);
    chk("pll_pin", rises - e0, 112);
    wr(12'h0f4, 32'h1e, 0);
    @(posedge core_clk_in) e0 = rises;
    repeat (64) @(posedge core_clk_in);
    chk("pd_pin", rises - e0, 0);
  endtask
  task automatic t_pin;
    int i;
    logic p;
    @(posedge core_clk_in) gpio_out_in <= 1;
    wr(12'h0f4, 32'h08, 0);
    chk("gpio_oe", clock_output_pin_oe_out, 0);
    chk("gpio_pin", clock_output_pin_out, 1);
    @(posedge core_clk_in) gpio_oe_in <= 1;
    @(negedge core_clk_in);
    chk("gpio_oe1", clock_output_pin_oe_out, 1);
    wr(12'h0f4, 32'h28, 0);
    chk("low", clock_output_pin_out, 0);
    chk("oe_on", clock_output_pin_oe_out, 1);
    wr(12'h0f4, 32'h30, 0);
    chk("oe_off", clock_output_pin_oe_out, 0);
    wr(12'h0f4, 32'h38, 0);
    chk("high", clock_output_pin_out, 1);
    for (i = 0; i < 4; i++) begin
      wr(12'h0f4, ((8 + i) << 4) | 8, 0);
      p = clock_output_pin_out;
      @(posedge core_clk_in) timer_overflow_in <= 4'h1 << i;
      @(posedge core_clk_in) timer_overflow_in <= 4'h1 << ((i + 1) % 4);
      @(posedge core_clk_in) timer_overflow_in <= 4'h0;
      repeat (4) @(negedge core_clk_in);
      chk("timer", clock_output_pin_out, !p);
    end
    wr(12'h0f4, 32'h38, 0);
    wr(12'h0f4, 32'hc8, 0);
    chk("rsv_sel", clock_output_pin_out, 0);
  endtask
  task automatic t_xtal;
    int k, e0;
    for (k = 0; k < 4; k++) begin
      wr(12'h0f4, ((4 + k) << 4) | 8, 0);
      @(posedge core_clk_in) e0 = rises;
      repeat (64) @(posedge core_clk_in);
      chk("xtal", rises - e0, 32 >> k);
    end
    @(posedge core_clk_in) ce_in <= 0;
    repeat (2) @(posedge core_clk_in);
    e0 = rises;
    repeat (32) @(posedge core_clk_in);
    chk("ce_hold", rises - e0, 0);
    @(posedge core_clk_in) ce_in <= 1;
  endtask
  task final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial forever #4 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) xtal_clk_in <= ~xtal_clk_in;
  initial begin
    #200000 num_errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1;
    t_regs();
    t_pll();
    t_pll_pin();
    t_pin();
    t_xtal();
    final_report();
  end
endmodule
`default_nettype wire

/* File: core/pcc_ratio_div.v */
// fractional clock generator: toggles output at num/den of the reference rate
`default_nettype none
module pcc_ratio_div #(
  parameter ACC_W = 16
) (
  // clock and control
  input wire core_clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire run_in,
  // ratio: output frequency = f_clk * num / (2 * den)
  input wire [ACC_W-1:0] num_in,
  input wire [ACC_W-1:0] den_in,
  // generated clock
  output wire clk_out
);
  reg [ACC_W:0] acc_ff;
  reg clk_ff;
  wire [ACC_W:0] sum = acc_ff + {1'b0, num_in};
  wire wrap = (sum >= {1'b0, den_in});
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      acc_ff <= {(ACC_W+1){1'b0}};
      clk_ff <= 1'b0;
    end else if (ce_in) begin
      if (!run_in) begin
        acc_ff <= {(ACC_W+1){1'b0}};
        clk_ff <= 1'b0;
      end else if (wrap) begin
        acc_ff <= sum - {1'b0, den_in};
        clk_ff <= ~clk_ff;
      end else begin
        acc_ff <= sum;
      end
    end
  end
  assign clk_out = clk_ff;
endmodule
`default_nettype wire

/* File: core/pcc_regs.vh */
// register map, field layout and timing constants of the pll clock output control
`ifndef PCC_REGS_VH
`define PCC_REGS_VH
`define PCC_IDX_LFO_TRIM 8'h3c
`define PCC_IDX_PLL_CTRL 8'h3d
`define PCC_IDX_PLL_DIV 8'h3e
`define PCC_ADDR_LFO_TRIM 10'h0f0
`define PCC_ADDR_PLL_CTRL 10'h0f4
`define PCC_ADDR_PLL_DIV 10'h0f8
`define PCC_ADDR_STATUS 10'h100
`define PCC_RST_LFO_TRIM 8'h80
`define PCC_RST_PLL_CTRL 8'h00
`define PCC_RST_PLL_DIV 8'h08
`define PCC_SEL_MSB 7
`define PCC_SEL_LSB 4
`define PCC_OE_BIT 3
`define PCC_PD_BIT 2
`define PCC_FB_MSB 1
`define PCC_FB_LSB 0
`define PCC_SEL_GPIO 4'h0
`define PCC_SEL_PLL 4'h1
`define PCC_SEL_LOW 4'h2
`define PCC_SEL_HIGH 4'h3
`define PCC_SEL_XTAL1 4'h4
`define PCC_SEL_XTAL8 4'h7
`define PCC_SEL_TMR0 4'h8
`define PCC_SEL_TMR3 4'hb
`define PCC_FB_23 5'h17
`define PCC_FB_27 5'h1b
`define PCC_FB_28 5'h1c
`define PCC_DIV_MIN 8'h08
`define PCC_XTAL_KHZ 27120
`define PCC_RESP_OKAY 2'h0
`define PCC_RESP_SLVERR 2'h2
`endif

/* File: core/pcc_top.v */
// pll clock output control: registers, pll frequency model and clock pin mux
// Function
// - eight-bit trim for slow oscillator; larger value gives lower frequency.
// - first stage multiplies 27.12 MHz crystal by feedback factor, then halves.
// - second stage divides first-stage frequency by output divider value.
// - select 0 gives general I/O, 1 PLL clock, 2 constant low, 3 high.
// - selects 4 to 7 give crystal divided by 1, 2, 4, 8.
// - selects 8 to Bh toggle pin on timer 0..3 overflow; C-F reserved.
// - output enable bit 3 gates the selected clock onto the pin; for select 0 the pin enable follows gpio_oe_in instead.
// - feedback select 00,01,10,11 gives factors 23,27,28,23.
// - output divider divides by value for 8..255; 0..7 reserved.
//
// Chosen here: the AXI4-Lite interface to the registers.
`default_nettype none
`include "pcc_regs.vh"
module pcc_top #(
  parameter ADDR_W = 12,
  parameter ACC_W = 16
) (
  // clock, reset, enable
  input wire core_clk_in,
  input wire nrst_in,
  input wire ce_in,
  // axi4-lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // axi4-lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // crystal-derived clocks and timer events
  input wire xtal_clk_in,
  input wire [3:0] timer_overflow_in,
  // general i/o path of the clock pin
  input wire gpio_out_in,
  input wire gpio_oe_in,
  // clock output pin
  input wire clock_output_pin_in,
  output wire clock_output_pin_out,
  output wire clock_output_pin_oe_out,
  // trim and pll state toward the analog part
  output wire [7:0] slow_osc_trim_value_out,
  output wire pll_clk_out,
  output wire [15:0] pll_vco_khz_out,
  output wire [15:0] pll_out_khz_out,
  output wire pll_div_reserved_out
);
  //////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] trim_ff;
  reg [7:0] ctrl_ff;
  reg [7:0] div_ff;
  reg aw_ff, w_ff, bvalid_ff, rvalid_ff;
  reg [ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;
  reg pin_ff, tog_ff;
  reg [2:0] xdiv_ff;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;

  wire [3:0] sel = ctrl_ff[`PCC_SEL_MSB:`PCC_SEL_LSB];
  wire pin_en = ctrl_ff[`PCC_OE_BIT];
  wire pll_power_down = ctrl_ff[`PCC_PD_BIT];
  wire [1:0] fb_sel = ctrl_ff[`PCC_FB_MSB:`PCC_FB_LSB];

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write
  // readies drop while frozen so no handshake is seen that the logic misses
  assign s_axi_awready = ~aw_ff & ~bvalid_ff & ce_in;
  assign s_axi_wready = ~w_ff & ~bvalid_ff & ce_in;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  wire aw_now = aw_ff | (s_axi_awvalid & s_axi_awready);
  wire w_now = w_ff | (s_axi_wvalid & s_axi_wready);
  wire [ADDR_W-1:0] wa = aw_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] ws = w_ff ? wstrb_ff : s_axi_wstrb;
  wire do_wr = aw_now & w_now & ~bvalid_ff;
  wire [9:0] wa_w = wa[9:0];
  wire wa_hi_zero = (wa >> 10) == {ADDR_W{1'b0}};
  wire wr_trim = do_wr & wa_hi_zero & (wa_w == `PCC_ADDR_LFO_TRIM) & ws[0];
  wire wr_ctrl = do_wr & wa_hi_zero & (wa_w == `PCC_ADDR_PLL_CTRL) & ws[0];
  wire wr_div = do_wr & wa_hi_zero & (wa_w == `PCC_ADDR_PLL_DIV) & ws[0];
  wire wr_known = wa_hi_zero & ((wa_w == `PCC_ADDR_LFO_TRIM) |
    (wa_w == `PCC_ADDR_PLL_CTRL) | (wa_w == `PCC_ADDR_PLL_DIV) |
    (wa_w == `PCC_ADDR_STATUS));

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PCC_RESP_OKAY;
      awaddr_ff <= {ADDR_W{1'b0}};
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      trim_ff <= `PCC_RST_LFO_TRIM;
      ctrl_ff <= `PCC_RST_PLL_CTRL;
      div_ff <= `PCC_RST_PLL_DIV;
    end else if (ce_in) begin
      if (s_axi_awvalid & s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
      end else begin
        aw_ff <= aw_now;
        w_ff <= w_now;
        if (bvalid_ff & s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
      if (wr_trim) begin
        trim_ff <= wd[7:0];
      end
      if (wr_ctrl) begin
        ctrl_ff <= wd[7:0];
      end
      if (wr_div) begin
        div_ff <= wd[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read
  assign s_axi_arready = ~rvalid_ff & ce_in;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  wire ra_hi_zero = (s_axi_araddr >> 10) == {ADDR_W{1'b0}};

  always @* begin
    nxt_rdata = 32'h0;
    nxt_rresp = `PCC_RESP_OKAY;
    if (!ra_hi_zero) begin
      nxt_rresp = `PCC_RESP_SLVERR;
    end else begin
      case (s_axi_araddr[9:0])
        `PCC_ADDR_LFO_TRIM: nxt_rdata = {24'h0, trim_ff};
        `PCC_ADDR_PLL_CTRL: nxt_rdata = {24'h0, ctrl_ff};
        `PCC_ADDR_PLL_DIV: nxt_rdata = {24'h0, div_ff};
        `PCC_ADDR_STATUS: nxt_rdata = {29'h0, pll_div_reserved_out, pll_clk_out,
          clock_output_pin_out};
        default: nxt_rresp = `PCC_RESP_SLVERR;
      endcase
    end
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `PCC_RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid & s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
      end else if (rvalid_ff & s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pll frequency model
  reg [4:0] fb_factor;
  always @* begin
    case (fb_sel)
      2'b00: fb_factor = `PCC_FB_23;
      2'b01: fb_factor = `PCC_FB_27;
      2'b10: fb_factor = `PCC_FB_28;
      default: fb_factor = `PCC_FB_23;
    endcase
  end
  localparam [15:0] XTAL_KHZ = `PCC_XTAL_KHZ;
  wire [20:0] vco_prod = XTAL_KHZ * fb_factor;
  wire [19:0] vco_khz = vco_prod[20:1];
  wire div_ok = (div_ff >= `PCC_DIV_MIN);
  wire pll_run = ~pll_power_down & div_ok;
  assign pll_vco_khz_out = pll_power_down ? 16'h0 : vco_khz[19:4];
  wire [19:0] out_khz = div_ok ? (vco_khz / div_ff) : 20'h0;
  assign pll_out_khz_out = pll_power_down ? 16'h0 : out_khz[15:0];
  assign pll_div_reserved_out = ~div_ok;

  // pll clock scaled to the core clock: rate f_clk*fb/(8*div)
  // den of four times div keeps num below den for every legal divider
  wire [ACC_W-1:0] pll_num = {{(ACC_W-5){1'b0}}, fb_factor};
  wire [ACC_W-1:0] pll_den = {{(ACC_W-10){1'b0}}, div_ff, 2'b00};
  pcc_ratio_div #(
    .ACC_W(ACC_W)
  ) u_pll_div (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .run_in(pll_run),
    .num_in(pll_num),
    .den_in(pll_den),
    .clk_out(pll_clk_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // crystal divider and timer toggle
  reg xtal_q_ff;
  // divider advances once per crystal period, not per core clock
  wire xtal_rise = xtal_clk_in & ~xtal_q_ff;
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      xdiv_ff <= 3'h0;
      xtal_q_ff <= 1'b0;
      tog_ff <= 1'b0;
    end else if (ce_in) begin
      xtal_q_ff <= xtal_clk_in;
      if (xtal_rise) begin
        xdiv_ff <= xdiv_ff + 3'h1;
      end
      if ((sel >= `PCC_SEL_TMR0) && (sel <= `PCC_SEL_TMR3) &&
          timer_overflow_in[sel[1:0]]) begin
        tog_ff <= ~tog_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock pin mux
  reg nxt_pin;
  always @* begin
    case (sel)
      `PCC_SEL_GPIO: nxt_pin = gpio_out_in;
      `PCC_SEL_PLL: nxt_pin = pll_clk_out & ~pll_power_down;
      `PCC_SEL_LOW: nxt_pin = 1'b0;
      `PCC_SEL_HIGH: nxt_pin = 1'b1;
      4'h4: nxt_pin = xtal_clk_in;
      4'h5: nxt_pin = xdiv_ff[0];
      4'h6: nxt_pin = xdiv_ff[1];
      `PCC_SEL_XTAL8: nxt_pin = xdiv_ff[2];
      4'h8, 4'h9, 4'ha, `PCC_SEL_TMR3: nxt_pin = tog_ff;
      default: nxt_pin = 1'b0;
    endcase
  end
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pin_ff <= 1'b0;
    end else if (ce_in) begin
      pin_ff <= nxt_pin;
    end
  end
  assign clock_output_pin_out = pin_ff;
  assign clock_output_pin_oe_out = (sel == `PCC_SEL_GPIO) ? gpio_oe_in : pin_en;
  assign slow_osc_trim_value_out = trim_ff;
endmodule
`default_nettype wire
